/* core/bwa_breaker_wear_accumulator.sv */
// breaker wear accumulator: per-phase/bin totals, counters, operate-time logs
// Function
// - each enabled opening of the monitored object adds phase current to phase total
// - five bins accumulate current by range
// - one current lands in exactly one bin
// - per-bin per-phase hit counters increment
// - primary change with zero bins restores defaults
// - hidden fraction bits block default restore
// - totals read as binary32, upper word first
// - writing zero clears a total
// - per-object opening counters, always counting
// - trip counter only on enabled protection trip
// - selection change swaps opening, keeps trip
// - opening and trip counters writable
// - per-input withdrawal counters on rising input
// - eight-entry logs with timestamps per category
// - moving average over twenty operate times
// - times logged while disabled if object selected
// - one clear command empties all logs
// - charge in seconds, open/close in milliseconds
// - logs read newest first as binary32 pairs
// - empty log entries read as zero
// - over-limit times read as NaN
`timescale 1ns/1ps
`default_nettype none
module bwa_breaker_wear_accumulator (
	input  wire logic                                        clk_sys,
	input  wire logic                                        reset,
	// breaker events
	input  wire logic [bwa_pkg::NUM_OBJ-1:0]                 objOpened,
	input  wire logic                                        protTrip,
	input  wire logic [bwa_pkg::NUM_PHASE-1:0][bwa_pkg::CUR_W-1:0] breakCurrent,
	input  wire logic                                        objSelected,
	input  wire logic [bwa_pkg::NUM_DIN-1:0]                 digitalIn,
	input  wire logic                                        primaryChanged,
	input  wire logic [bwa_pkg::CUR_W-1:0]                   primaryValue,
	// operate-time completion: ms for open/close, s for charge, 16.16
	input  wire logic                                        opDone,
	input  wire logic [1:0]                                  opCategory,
	input  wire logic [bwa_pkg::TIME_W-1:0]                  opTime,
	input  wire logic [bwa_pkg::TS_W-1:0]                    timeStamp,
	// register port
	input  wire logic [bwa_pkg::ADDR_W-1:0]                  regAddr,
	input  wire logic [bwa_pkg::DATA_W-1:0]                  regWrData,
	input  wire logic                                        regWrite,
	input  wire logic                                        regRead,
	output logic      [bwa_pkg::DATA_W-1:0]                  regRdData,
	// status
	output logic      [bwa_pkg::CNT_W-1:0]                   openCount,
	output logic      [bwa_pkg::CNT_W-1:0]                   tripCount
);
	// ============================================================
	// state
	// totals carry eight guard bits above the 16.16 current, so that a
	// long service life of heavy breaks does not wrap a sum; the lowest
	// sixteen bits are the fraction, cut short in a float read above 256 A but still nonzero
	localparam int W = bwa_pkg::CUR_W + 8;

	bwa_pkg::bwa_state_t st;
	bwa_pkg::bwa_state_t next_st;

	// ============================================================
	// number conversions
	// the float pack truncates the mantissa rather than rounding, so a
	// read of a total may sit one unit in the last place below the sum
	// fixed point (16.16, unsigned) to binary32
	function automatic logic [31:0] toFloat(input logic [W-1:0] v);
		logic [5:0]  msb;
		logic [W-1:0] norm;
		logic [7:0]  ex;
		msb  = '0;
		norm = '0;
		ex   = '0;
		if (v == '0) begin
			return bwa_pkg::FLOAT_ZERO;
		end
		// find the highest set bit; zero was answered above
		for (int i = 0; i < W; i++) begin
			if (v[i]) begin
				msb = 6'(i);
			end
		end
		// move the leading one to the top; it becomes the hidden bit
		norm = v << (6'(W - 1) - msb);
		// exponent: bias plus bit position relative to the 16.16 point
		ex   = 8'(bwa_pkg::FLOAT_BIAS + 8'(msb) - 8'(bwa_pkg::FLOAT_POINT));
		return {1'b0, ex, norm[W-2 -: 23]};
	endfunction : toFloat

	// binary32 to 16.16 fixed point, truncating
	function automatic logic [W-1:0] fromFloat(input logic [31:0] f);
		logic [W+23:0] m;
		int           sh;
		m  = '0;
		sh = 0;
		// denormals and negative values mean nothing for a current total
		if (f[30:23] == 8'h00 || f[31]) begin
			return '0;
		end
		m  = {{W{1'b0}}, 1'b1, f[22:0]};
		sh = int'(f[30:23]) - int'(bwa_pkg::FLOAT_BIAS) + int'(bwa_pkg::FLOAT_POINT) - 23;
		// shift distance between the float point and the 16.16 point
		if (sh >= 0) begin
			m = m << sh;
		end else begin
			m = m >> (-sh);
		end
		return m[W-1:0];
	endfunction : fromFloat

	// ============================================================
	// bin and log helpers
	// bin index of a current, lower inclusive, upper exclusive
	function automatic logic [2:0] binOf(input logic [bwa_pkg::CUR_W-1:0] c,
		input logic [bwa_pkg::NUM_BIN-2:0][bwa_pkg::CUR_W-1:0] lim);
		logic [2:0] b;
		// scan from the top limit down so the lowest matching bin wins;
		// zero limits after reset push every current into the last bin
		b = 3'(bwa_pkg::NUM_BIN - 1);
		for (int k = bwa_pkg::NUM_BIN - 2; k >= 0; k--) begin
			if (c < lim[k]) begin
				b = 3'(k);
			end
		end
		return b;
	endfunction : binOf

	// log entry as float with zero and nan handling
	function automatic logic [31:0] logFloat(input logic valid, input logic [1:0] cat,
		input logic [bwa_pkg::TIME_W-1:0] t);
		logic over;
		// over-limit test on the integer part, plus any fraction above it
		over = (cat == bwa_pkg::CAT_CHARGE) ?
			(t[31:16] > bwa_pkg::CHARGE_MAX_S ||
			 (t[31:16] == bwa_pkg::CHARGE_MAX_S && t[15:0] != '0)) :
			(t[31:16] > bwa_pkg::OPEN_CLOSE_MAX_MS ||
			 (t[31:16] == bwa_pkg::OPEN_CLOSE_MAX_MS && t[15:0] != '0));
		// a time equal to the limit is still a number; only above is NaN
		if (!valid) begin
			return bwa_pkg::FLOAT_ZERO;
		end
		if (over) begin
			return bwa_pkg::FLOAT_NAN;
		end
		return toFloat(W'(t));
	endfunction : logFloat

	// ============================================================
	// next-state logic
	always_comb begin
		logic [2:0]        b;
		logic              binsZero;
		logic [W-1:0]      wval;
		logic [7:0]        off;
		logic [31:0]       f;
		logic [1:0]        cat;
		logic [2:0]        idx;
		logic [4:0]        wi;
		// every local gets a value before any use
		b        = '0;
		binsZero = 1'b1;
		wval     = '0;
		off      = '0;
		f        = '0;
		cat      = '0;
		idx      = '0;
		wi       = '0;
		// hold everything by default; the read word lasts one cycle only
		next_st  = st;
		next_st.readData = '0;

		// every object has its own counter; the selection only picks the
		// one reported, so switching objects never loses a count
		// per-object opening counters count even when disabled
		for (int o = 0; o < bwa_pkg::NUM_OBJ; o++) begin
			if (objOpened[o]) begin
				next_st.openCnt[o] = st.openCnt[o] + 1'b1;
			end
		end

		// totals and bins move only while monitoring is enabled; a zero
		// current lands in a bin total but does not count as a hit
		// monitored object opened: totals, bins, trip count
		if (objSelected && objOpened[st.objSel]) begin
			if (st.enable) begin
				for (int p = 0; p < bwa_pkg::NUM_PHASE; p++) begin
					b = binOf(breakCurrent[p], st.binLimit);
					next_st.phTotal[p] = st.phTotal[p] + W'(breakCurrent[p]);
					next_st.binTotal[b][p] = st.binTotal[b][p] + W'(breakCurrent[p]);
					if (breakCurrent[p] != '0) begin
						next_st.binCount[b][p] = st.binCount[b][p] + 1'b1;
					end
				end
				// trips follow the monitored object's openings only
				if (protTrip) begin
					next_st.tripCnt = st.tripCnt + 1'b1;
				end
			end
		end

		// history is kept for every input, selected or not, so that a
		// change of selection cannot fake a withdrawal
		// withdrawal counting on each input rising
		for (int d = 0; d < bwa_pkg::NUM_DIN; d++) begin
			if (digitalIn[d] && !st.dinLast[d]) begin
				next_st.wdrawCnt[d] = st.wdrawCnt[d] + 1'b1;
			end
		end
		next_st.dinLast = digitalIn;

		// any nonzero bin total, down to one fraction bit, keeps the old
		// ranges, so wear already booked is not reshuffled by scaling
		// default ranges when primary changes and all bins exactly zero
		for (int k = 0; k < bwa_pkg::NUM_BIN; k++) begin
			for (int p = 0; p < bwa_pkg::NUM_PHASE; p++) begin
				if (st.binTotal[k][p] != '0) begin
					binsZero = 1'b0;
				end
			end
		end
		if (primaryChanged && binsZero) begin
			for (int k = 0; k < bwa_pkg::NUM_BIN - 1; k++) begin
				next_st.binLimit[k] = bwa_pkg::CUR_W'(primaryValue *
					(bwa_pkg::DEFAULT_BIN_STEP_MULT << k));
			end
		end

		// the logs are shift registers: entry zero is the newest and the
		// oldest falls off the end; an unknown category is ignored
		// operate-time logging, needs only a selected object
		if (opDone && objSelected && opCategory < 2'(bwa_pkg::NUM_CAT)) begin
			cat = opCategory;
			for (int i = bwa_pkg::LOG_DEPTH - 1; i > 0; i--) begin
				next_st.logTime[cat][i]  = st.logTime[cat][i-1];
				next_st.logStamp[cat][i] = st.logStamp[cat][i-1];
				next_st.logValid[cat][i] = st.logValid[cat][i-1];
			end
			next_st.logTime[cat][0]  = opTime;
			next_st.logStamp[cat][0] = timeStamp;
			next_st.logValid[cat][0] = 1'b1;
			// below the window the sum is exact; once full, one mean is
			// taken out per sample, close to a true window at low cost
			// cumulative moving average, window grows to twenty
			if (st.avgN[cat] < 5'(bwa_pkg::AVG_WINDOW)) begin
				next_st.avgN[cat]   = st.avgN[cat] + 1'b1;
				next_st.avgSum[cat] = st.avgSum[cat] + 37'(opTime);
			end else begin
				next_st.avgSum[cat] = st.avgSum[cat] + 37'(opTime) -
					37'(st.avgSum[cat] / 37'(bwa_pkg::AVG_WINDOW));
			end
		end

		// float pairs: the even word only parks the upper half and the
		// odd word commits the whole value, so no half-written total
		// is ever seen by the accumulation logic
		// register writes
		if (regWrite) begin
			off = regAddr;
			if (off[0] == 1'b0) begin
				next_st.hiLatch = regWrData;
			end
			wval = fromFloat({st.hiLatch, regWrData});
			if (off >= bwa_pkg::REG_PH_TOTAL && off < bwa_pkg::REG_PH_TOTAL + 8'h06
				&& off[0]) begin
				next_st.phTotal[2'((off - bwa_pkg::REG_PH_TOTAL) >> 1)] = wval;
			end
			if (off >= bwa_pkg::REG_BIN_TOTAL && off < bwa_pkg::REG_BIN_TOTAL + 8'h1e
				&& off[0]) begin
				wi = 5'((off - bwa_pkg::REG_BIN_TOTAL) >> 1);
				next_st.binTotal[3'(wi / 5'd3)][2'(wi % 5'd3)] = wval;
			end
			// limits are writable to set ranges by hand; a limit below its
			// neighbour simply leaves the bins in between empty
			if (off >= bwa_pkg::REG_LIMIT && off < bwa_pkg::REG_LIMIT + 8'h08 && off[0]) begin
				next_st.binLimit[2'((off - bwa_pkg::REG_LIMIT) >> 1)] =
					bwa_pkg::CUR_W'(wval);
			end
			// single-word registers; a write overrides a count in the same
			// cycle, since the written value is what software asked for
			case (off)
				bwa_pkg::REG_OPEN_CNT: next_st.openCnt[st.objSel] = regWrData;
				bwa_pkg::REG_TRIP_CNT: next_st.tripCnt = regWrData;
				bwa_pkg::REG_WDRAW_CNT: next_st.wdrawCnt[st.dinSel] = regWrData;
				bwa_pkg::REG_CTRL: begin
					next_st.enable = regWrData[bwa_pkg::CTRL_EN_BIT];
					next_st.objSel = regWrData[bwa_pkg::CTRL_OBJ_LSB +: 2];
					next_st.dinSel = regWrData[bwa_pkg::CTRL_DIN_LSB +: 3];
				end
				bwa_pkg::REG_CLEAR_LOG: begin
					next_st.logValid = '0;
					next_st.avgSum   = '0;
					next_st.avgN     = '0;
				end
				default: ;
			endcase
		end

		// the answer is built here and registered, so it stands only in
		// the cycle after the strobe and reads zero in every other cycle;
		// single-word registers answer at their own address, always with the lower half
		// register reads, data the cycle after
		if (regRead) begin
			off = regAddr;
			f   = '0;
			if (off < bwa_pkg::REG_PH_TOTAL + 8'h06) begin
				f = toFloat(st.phTotal[2'(off >> 1)]);
			end else if (off >= bwa_pkg::REG_BIN_TOTAL && off < bwa_pkg::REG_BIN_TOTAL + 8'h1e) begin
				wi = 5'((off - bwa_pkg::REG_BIN_TOTAL) >> 1);
				f  = toFloat(st.binTotal[3'(wi / 5'd3)][2'(wi % 5'd3)]);
			end else if (off >= bwa_pkg::REG_BIN_COUNT && off < bwa_pkg::REG_BIN_COUNT + 8'h0f) begin
				wi = 5'(off - bwa_pkg::REG_BIN_COUNT);
				f  = {16'h0000, st.binCount[3'(wi / 5'd3)][2'(wi % 5'd3)]};
				off[0] = 1'b1;
			end else if (off >= bwa_pkg::REG_AVG && off < bwa_pkg::REG_AVG + 8'h06) begin
				cat = 2'((off - bwa_pkg::REG_AVG) >> 1);
				f = (st.avgN[cat] == '0) ? bwa_pkg::FLOAT_ZERO :
					logFloat(1'b1, cat, 32'(st.avgSum[cat] / 37'(st.avgN[cat])));
			end else if (off >= bwa_pkg::REG_LOG && off < bwa_pkg::REG_LOG + 8'h30) begin
				cat = 2'((off - bwa_pkg::REG_LOG) >> 4);
				idx = 3'((off - bwa_pkg::REG_LOG) >> 1);
				f   = logFloat(st.logValid[cat][idx], cat, st.logTime[cat][idx]);
			end else if (off >= bwa_pkg::REG_STAMP && off < bwa_pkg::REG_STAMP + 8'h30) begin
				cat = 2'((off - bwa_pkg::REG_STAMP) >> 4);
				idx = 3'((off - bwa_pkg::REG_STAMP) >> 1);
				f   = st.logValid[cat][idx] ? st.logStamp[cat][idx] : '0;
			end else if (off >= bwa_pkg::REG_LIMIT && off < bwa_pkg::REG_LIMIT + 8'h08) begin
				f = toFloat(W'(st.binLimit[2'((off - bwa_pkg::REG_LIMIT) >> 1)]));
			end else begin
				case (off)
					bwa_pkg::REG_OPEN_CNT:  f = {16'h0000, st.openCnt[st.objSel]};
					bwa_pkg::REG_TRIP_CNT:  f = {16'h0000, st.tripCnt};
					bwa_pkg::REG_WDRAW_CNT: f = {16'h0000, st.wdrawCnt[st.dinSel]};
					bwa_pkg::REG_CTRL: f = {16'h0000, 5'h00, st.dinSel, 2'h0, st.objSel,
						3'h0, st.enable};
					default: f = '0;
				endcase
				off[0] = 1'b1;
			end
			// odd address takes the lower half, even the upper
			next_st.readData = off[0] ? f[15:0] : f[31:16];
		end
	end

	// ============================================================
	// state register
	// one synchronous reset clears every total, counter, log and limit;
	// after it all currents go to the last bin until a scaling change or a limit write
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ports straight from the state; only openCount passes a mux on objSel
	assign regRdData = st.readData;
	assign openCount = st.openCnt[st.objSel];
	assign tripCount = st.tripCnt;
endmodule : bwa_breaker_wear_accumulator
`default_nettype wire

/* core/bwa_pkg.sv */
// package: constants and types of the breaker wear accumulator
package bwa_pkg;
	// ============================================================
	// sizes
	localparam int NUM_PHASE    = 3;
	localparam int NUM_BIN      = 5;
	localparam int NUM_OBJ      = 4;
	localparam int NUM_DIN      = 8;
	localparam int LOG_DEPTH    = 8;
	localparam int AVG_WINDOW   = 20;
	localparam int CUR_W        = 32;  // current, 16.16 fixed point amperes
	localparam int FRAC_W       = 16;
	localparam int CNT_W        = 16;
	localparam int TIME_W       = 32;  // operate time in ms or s, 16.16 fixed
	localparam int TS_W         = 32;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 16;
	// ============================================================
	// operate-time categories
	localparam logic [1:0] CAT_OPEN   = 2'h0;
	localparam logic [1:0] CAT_CLOSE  = 2'h1;
	localparam logic [1:0] CAT_CHARGE = 2'h2;
	localparam int NUM_CAT = 3;
	// ============================================================
	// nan limits, integer part of 16.16 value
	localparam logic [15:0] OPEN_CLOSE_MAX_MS = 16'd300;
	localparam logic [15:0] CHARGE_MAX_S      = 16'd60;
	localparam logic [31:0] FLOAT_NAN         = 32'h7fc00000;
	localparam logic [31:0] FLOAT_ZERO        = 32'h00000000;
	localparam logic [7:0]  FLOAT_BIAS        = 8'h7f;
	localparam logic [4:0]  FLOAT_POINT       = 5'h10;
	localparam logic [CUR_W-1:0] DEFAULT_BIN_STEP_MULT = 32'h00000002;
	// ============================================================
	// holding register map, word addresses (upper half at even address)
	localparam logic [ADDR_W-1:0] REG_PH_TOTAL   = 8'h00; // 3 pairs
	localparam logic [ADDR_W-1:0] REG_BIN_TOTAL  = 8'h10; // 15 pairs, bin*3+phase
	localparam logic [ADDR_W-1:0] REG_BIN_COUNT  = 8'h30; // 15 words
	localparam logic [ADDR_W-1:0] REG_OPEN_CNT   = 8'h40;
	localparam logic [ADDR_W-1:0] REG_TRIP_CNT   = 8'h41;
	localparam logic [ADDR_W-1:0] REG_WDRAW_CNT  = 8'h42;
	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h43; // enable, obj sel, din sel
	localparam logic [ADDR_W-1:0] REG_CLEAR_LOG  = 8'h44;
	localparam logic [ADDR_W-1:0] REG_AVG        = 8'h48; // 3 pairs
	localparam logic [ADDR_W-1:0] REG_LOG        = 8'h60; // 3 blocks of 16 words
	localparam logic [ADDR_W-1:0] REG_STAMP      = 8'h90; // 3 blocks of 16 words
	localparam logic [ADDR_W-1:0] REG_LIMIT      = 8'hc0; // 4 pairs, bin upper limits
	localparam logic [ADDR_W-1:0] LOG_BLOCK      = 8'h10;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_OBJ_LSB = 4;
	localparam int CTRL_DIN_LSB = 8;
	// ============================================================
	// state of the block
	typedef struct packed {
		logic [NUM_PHASE-1:0][CUR_W+8-1:0]           phTotal;
		logic [NUM_BIN-1:0][NUM_PHASE-1:0][CUR_W+8-1:0] binTotal;
		logic [NUM_BIN-1:0][NUM_PHASE-1:0][CNT_W-1:0] binCount;
		logic [NUM_BIN-2:0][CUR_W-1:0]               binLimit;
		logic [NUM_OBJ-1:0][CNT_W-1:0]               openCnt;
		logic [CNT_W-1:0]                            tripCnt;
		logic [NUM_DIN-1:0][CNT_W-1:0]               wdrawCnt;
		logic [NUM_DIN-1:0]                          dinLast;
		logic                                        enable;
		logic [1:0]                                  objSel;
		logic [2:0]                                  dinSel;
		logic [15:0]                                 hiLatch;
		logic [NUM_CAT-1:0][LOG_DEPTH-1:0][TIME_W-1:0] logTime;
		logic [NUM_CAT-1:0][LOG_DEPTH-1:0][TS_W-1:0]   logStamp;
		logic [NUM_CAT-1:0][LOG_DEPTH-1:0]             logValid;
		logic [NUM_CAT-1:0][TIME_W+5-1:0]              avgSum;
		logic [NUM_CAT-1:0][4:0]                       avgN;
		logic [DATA_W-1:0]                             readData;
	} bwa_state_t;
endpackage : bwa_pkg

/* sim/bwa_breaker_wear_accumulator_sva.sv */
// checker: port-level assertions of the breaker wear accumulator
`timescale 1ns/1ps
`default_nettype none
module bwa_accum_sva (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [3:0]  objOpened,
	input wire logic        protTrip,
	input wire logic [7:0]  regAddr,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdData,
	input wire logic [15:0] openCount,
	input wire logic [15:0] tripCount
);
	// ============================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// quiet cycle: no opening and no register write
	sequence quiet;
		objOpened == 4'h0 && !regWrite;
	endsequence
	chk_read_idle: assert property (!$past(regRead) |-> regRdData == 16'h0000)
		else $error("read data not zero outside a read answer");
	chk_open_hold: assert property (quiet [*3] |-> $stable(openCount))
		else $error("opening count moved without an opening");
	chk_trip_hold: assert property (((objOpened == 4'h0 || !protTrip) && !regWrite) [*3]
		|-> $stable(tripCount))
		else $error("trip count moved without a trip");
	chk_open_step: assert property (!regWrite [*3] |->
		openCount == $past(openCount) || openCount == $past(openCount) + 16'h0001)
		else $error("opening count stepped by more than one");
	chk_trip_open: assert property (!regWrite [*3] ##0 tripCount != $past(tripCount)
		|-> openCount != $past(openCount))
		else $error("trip counted without an opening");
	chk_open_read: assert property (quiet [*3] ##0 regRead && regAddr == bwa_pkg::REG_OPEN_CNT
		|=> regRdData == openCount)
		else $error("opening count word differs from port");
	chk_trip_read: assert property (quiet [*3] ##0 regRead && regAddr == bwa_pkg::REG_TRIP_CNT
		|=> regRdData == tripCount)
		else $error("trip count word differs from port");
	chk_unmapped_zero: assert property (regRead && regAddr == 8'h45 |=> regRdData == 16'h0000)
		else $error("unmapped word not zero");
	chk_clear_log: assert property (regWrite && regAddr == bwa_pkg::REG_CLEAR_LOG ##1
		regRead && regAddr[7:4] == 4'h6 |=> regRdData == 16'h0000)
		else $error("open log not empty after clear");
	cover property (objOpened != 4'h0 && protTrip);
	cover property (regWrite && regAddr == bwa_pkg::REG_CLEAR_LOG);
	cover property (tripCount != $past(tripCount));
endmodule : bwa_accum_sva
bind bwa_breaker_wear_accumulator bwa_accum_sva u_bwa_accum_sva (.clk_sys, .reset, .objOpened,
	.protTrip, .regAddr, .regWrite, .regRead, .regRdData, .openCount, .tripCount);
`default_nettype wire

/* sim/bwa_breaker_model.sv */
// partner: monitored breaker, drives opening pulses, trip level and break currents
`timescale 1ns/1ps
`default_nettype none
module bwa_breaker_model (
	input  wire logic             clk_sys,
	input  wire logic [3:0]       openReq,
	input  wire logic             tripReq,
	input  wire logic [2:0][31:0] curReq,
	output var  logic [3:0]       objOpened,
	output var  logic             protTrip,
	output var  logic [2:0][31:0] breakCurrent
);
	// ============================================================
	// contacts open one cycle after the request; current only valid with it
	initial begin
		objOpened = 4'h0;
		protTrip = 1'b0;
		breakCurrent = '0;
	end
	always @(posedge clk_sys) begin
		objOpened <= openReq;
		if (openReq != 4'h0) begin
			protTrip     <= tripReq;
			breakCurrent <= curReq;
		end else begin
			protTrip     <= ~protTrip; // no meaning outside an opening
			breakCurrent <= ~breakCurrent;
		end
	end
endmodule : bwa_breaker_model
`default_nettype wire

/* sim/bwa_testbench.sv */
// testbench: directed scenarios for the breaker wear accumulator
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ============================================================
	// signals
	logic             clk_sys;
	logic             reset;
	logic [3:0]       openReq;
	logic             tripReq;
	logic [2:0][31:0] curReq;
	logic [3:0]       objOpened;
	logic             protTrip;
	logic [2:0][31:0] breakCurrent;
	logic             objSelected;
	logic [7:0]       digitalIn;
	logic             primaryChanged;
	logic [31:0]      primaryValue;
	logic             opDone;
	logic [1:0]       opCategory;
	logic [31:0]      opTime;
	logic [31:0]      timeStamp;
	logic [7:0]       regAddr;
	logic [15:0]      regWrData;
	logic             regWrite;
	logic             regRead;
	logic [15:0]      regRdData;
	logic [15:0]      openCount;
	logic [15:0]      tripCount;
	int               n_errors;
	int               samples_checked;
	int               i;
	bwa_breaker_model u_bwa_breaker_model (.clk_sys, .openReq, .tripReq, .curReq, .objOpened,
		.protTrip, .breakCurrent);
	bwa_breaker_wear_accumulator u_bwa_breaker_wear_accumulator (.clk_sys, .reset, .objOpened,
		.protTrip, .breakCurrent, .objSelected, .digitalIn, .primaryChanged, .primaryValue,
		.opDone, .opCategory, .opTime, .timeStamp, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .openCount, .tripCount);
	// ============================================================
	// clock and bus tasks
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite  <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 cmp(regRdData, e);
	endtask : rd
	// opening of objects o with currents 2.0, 1.0, 16.0 A
	task automatic brk(input logic [3:0] o, input logic t);
		@(posedge clk_sys);
		openReq <= o;
		tripReq <= t;
		curReq  <= {32'h00100000, 32'h00010000, 32'h00020000};
		@(posedge clk_sys);
		openReq <= 4'h0;
		repeat (4) @(posedge clk_sys);
	endtask : brk
	task automatic prim(input logic [31:0] v);
		@(posedge clk_sys);
		primaryChanged <= 1'b1;
		primaryValue   <= v;
		@(posedge clk_sys);
		primaryChanged <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : prim
	task automatic op(input logic [1:0] c, input logic [31:0] t);
		@(posedge clk_sys);
		opDone     <= 1'b1;
		opCategory <= c;
		opTime     <= t;
		timeStamp  <= timeStamp + 32'h1;
		@(posedge clk_sys);
		opDone     <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : op
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	// ============================================================
	// scenarios
	task automatic t_accum;
		rd(8'h45, 16'h0000);
		wr(bwa_pkg::REG_CTRL, 16'h0011);
		prim(32'h00010000);
		rd(8'hc0, 16'h4000);
		brk(4'h2, 1'b0);
		brk(4'h2, 1'b1);
		rd(8'h00, 16'h4080);
		rd(8'h01, 16'h0000);
		rd(8'h16, 16'h4080);
		rd(8'h10, 16'h0000);
		rd(8'h12, 16'h4000);
		rd(8'h2c, 16'h4200);
		rd(8'h33, 16'h0002);
		cmp(tripCount, 16'h0001);
		prim(32'h00020000);
		rd(8'hc0, 16'h4000);
		wr(8'h00, 16'h0000);
		wr(8'h01, 16'h0000);
		rd(8'h00, 16'h0000);
		wr(8'h02, 16'h4200);
		wr(8'h03, 16'h0000);
		rd(8'h02, 16'h4200);
	endtask : t_accum
	task automatic t_counters;
		wr(bwa_pkg::REG_CTRL, 16'h0020);
		brk(4'h4, 1'b1);
		brk(4'h1, 1'b1);
		cmp(openCount, 16'h0001);
		cmp(tripCount, 16'h0001);
		wr(bwa_pkg::REG_CTRL, 16'h0011);
		repeat (3) @(posedge clk_sys);
		cmp(openCount, 16'h0002);
		cmp(tripCount, 16'h0001);
		wr(bwa_pkg::REG_TRIP_CNT, 16'h0007);
		wr(bwa_pkg::REG_OPEN_CNT, 16'h0005);
		rd(bwa_pkg::REG_TRIP_CNT, 16'h0007);
		rd(bwa_pkg::REG_OPEN_CNT, 16'h0005);
		for (i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			digitalIn <= (i % 2 == 1) ? 8'h00 : ((i < 4) ? 8'h28 : 8'h20);
		end
		wr(bwa_pkg::REG_CTRL, 16'h0311);
		rd(bwa_pkg::REG_WDRAW_CNT, 16'h0002);
		wr(bwa_pkg::REG_CTRL, 16'h0511);
		rd(bwa_pkg::REG_WDRAW_CNT, 16'h0003);
	endtask : t_counters
	task automatic t_logs;
		wr(bwa_pkg::REG_CTRL, 16'h0010);
		op(bwa_pkg::CAT_OPEN, 32'h000a0000);
		op(bwa_pkg::CAT_OPEN, 32'h012c0000);
		op(bwa_pkg::CAT_OPEN, 32'h012d0000);
		objSelected <= 1'b0;
		op(bwa_pkg::CAT_OPEN, 32'h00050000);
		objSelected <= 1'b1;
		rd(8'h60, 16'h7fc0);
		rd(8'h62, 16'h4396);
		rd(8'h64, 16'h4120);
		rd(8'h66, 16'h0000);
		rd(8'h91, 16'h0003);
		op(bwa_pkg::CAT_CHARGE, 32'h003c0000);
		rd(8'h4c, 16'h4270);
		op(bwa_pkg::CAT_CHARGE, 32'h003d0000);
		rd(8'h80, 16'h7fc0);
		rd(8'h82, 16'h4270);
		for (i = 1; i < 10; i++)
			op(bwa_pkg::CAT_CLOSE, {16'(i), 16'h0000});
		rd(8'h70, 16'h4110);
		rd(8'h7e, 16'h4000);
		rd(8'h4a, 16'h40a0);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr  <= bwa_pkg::REG_CLEAR_LOG;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		regRead  <= 1'b1;
		regAddr  <= 8'h60;
		@(posedge clk_sys);
		regRead  <= 1'b0;
		#1 cmp(regRdData, 16'h0000);
		rd(8'h70, 16'h0000);
		rd(8'h4a, 16'h0000);
	endtask : t_logs
	// ============================================================
	// main sequence and hang guard
	initial begin
		n_errors = 0;
		samples_checked = 0;
		{reset, objSelected} = 2'b11;
		{openReq, tripReq, curReq, digitalIn, primaryChanged, primaryValue} = '0;
		{opDone, opCategory, opTime, timeStamp, regAddr, regWrData, regWrite, regRead} = '0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(bwa_pkg::REG_OPEN_CNT, 16'h0000);
		t_accum;
		t_counters;
		t_logs;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		complete_run;
	end
endmodule : testbench
`default_nettype wire
